// >>> ldi_pkg.sv
// ldi_pkg: constants, types and state layout for the dimming input block.
// assumes a 10 MHz core clock; pins reach the block unsynchronised.
package ldi_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int LOAD_TIME_NS = 400;
	localparam int LOAD_CYC_I = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] LOAD_CYC = LOAD_CYC_I[3:0];
	localparam logic [7:0] OSC_DIV_DEF = 8'h04;

	// ------------------------------------------------------------
	// synchroniser bit positions
	// ------------------------------------------------------------
	localparam int SYN_W = 13;
	localparam int IX_D01 = 0;
	localparam int IX_D23 = 1;
	localparam int IX_D4 = 2;
	localparam int IX_D5 = 3;
	localparam int IX_SYNC = 4;
	localparam int IX_FS = 5;
	localparam int IX_EN = 6;
	localparam int IX_RAIL = 7;
	localparam int IX_FAULT = 8;
	localparam int IX_MHI = 9;
	localparam int IX_MLO = 10;
	localparam int IX_SLAVE = 11;
	localparam int IX_EXT = 12;

	// ------------------------------------------------------------
	// register map (byte offsets) and fields
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_CLEAR = 5'h04;
	localparam logic [4:0] OFS_IEN = 5'h08;
	localparam logic [4:0] OFS_CTRL = 5'h0C;
	localparam logic [4:0] OFS_ACTIVE = 5'h10;
	localparam logic [4:0] OFS_INFO = 5'h14;
	localparam int EV_LOAD = 0;
	localparam int EV_FAULT = 1;
	localparam int EV_PRETEST = 2;
	localparam int EV_W = 3;
	localparam int SHIFT_W = 8;
	localparam logic [SHIFT_W-1:0] ACT_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_DECODE = 3'b010,
		ST_RUN = 3'b100
	} ldi_state_e;

	typedef enum logic [1:0] {
		MODE_PWM = 2'b00,
		MODE_SER = 2'b01,
		MODE_DC = 2'b10
	} ldi_mode_e;

	typedef struct packed {
		logic [SYN_W-1:0] s1;
		logic [SYN_W-1:0] s2;
		logic [SYN_W-1:0] s3;
		ldi_state_e state;
		ldi_mode_e mode;
		logic slave;
		logic [7:0] osc_cnt;
		logic half_clk;
		logic turn_on;
		logic [SHIFT_W-1:0] shift;
		logic [SHIFT_W-1:0] act;
		logic [3:0] load_cnt;
		logic load_armed;
		logic [EV_W-1:0] sts;
		logic [EV_W-1:0] ien;
		logic ctrl_off;
		logic [7:0] rdata;
		logic pretest;
		logic fault_drv;
		logic [5:0] ch_en;
	} ldi_st_s;

endpackage

// >>> ldi_core.sv
// ldi_core: digital side of a six-channel dimming input interface.
// assumes pin levels arrive asynchronously and the analog front end
// reports mode, rail, fault and clock-source levels as logic inputs.
//
// Overview of operation
// - pwm mode, pair01 input gates ch0 and ch1
// - pwm mode, pair23 input gates ch2 and ch3
// - pwm mode, ch4 input gates channel 4
// - pwm mode, ch5 input gates channel 5
// - serial mode, pair01 pin is serial data
// - serial mode, pair23 pin is serial clock
// - host pulls load pin low; data latched
// - device holds load pin low while loading
// - cascade clock is half the internal clock
// - turn-on output changes at cascade clock rise
// - pwm slave uses sync input for pretest
// - fault flag pulled low on open string
// - enable floats high runs, grounded disables
// - external clock on freq pin replaces oscillator
// - mode pin picks pwm, serial or dc
// - rail sense tied high makes a slave
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module ldi_core
	import ldi_pkg::*;
#(
	parameter logic [7:0] OSC_DIV = OSC_DIV_DEF
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic pair01_gate_serdata_pin_in,
	input wire logic pair23_gate_serclk_pin_in,
	input wire logic ch4_gate_load_pin_in,
	output logic ch4_gate_load_pin_out,
	output logic ch4_gate_load_pin_oe_n_out,
	input wire logic ch5_gate_pin_in,
	input wire logic osc_freq_set_pin_in,
	input wire logic ext_clk_sel_in,
	input wire logic enable_pin_in,
	input wire logic mode_at_vcc_in,
	input wire logic mode_at_gnd_in,
	input wire logic rail_sense_input_in,
	input wire logic rail_ok_in,
	input wire logic open_string_in,
	input wire logic cascade_sync_pin_in,
	output logic cascade_sync_pin_out,
	output logic cascade_sync_pin_oe_n_out,
	output logic cascade_half_rate_clock_out,
	output logic fault_flag_out,
	output logic fault_flag_oe_n_out,
	output logic [5:0] ch_en_out,
	output logic pretest_start_out,
	input wire logic [4:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic irq_out
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// rising edge of a synchronised pin: second stage against third
	function automatic logic rise_of(input logic [SYN_W-1:0] now,
		input logic [SYN_W-1:0] prev, input int ix);
		rise_of = now[ix] & ~prev[ix];
	endfunction

	ldi_st_s st_r;
	ldi_st_s st_nxt;
	logic [SYN_W-1:0] pins;
	logic tick;
	logic ser_run;
	logic load_start;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	// pins gathered so one two-flop chain covers them all
	assign pins = {ext_clk_sel_in, rail_sense_input_in, mode_at_gnd_in, mode_at_vcc_in,
		open_string_in, rail_ok_in, enable_pin_in, osc_freq_set_pin_in,
		cascade_sync_pin_in, ch5_gate_pin_in, ch4_gate_load_pin_in,
		pair23_gate_serclk_pin_in, pair01_gate_serdata_pin_in};

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		ev = '0;
		clr = '0;
		tick = 1'b0;
		ser_run = 1'b0;
		load_start = 1'b0;

		// synchronisers: s1 feeds only s2
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;

		// enable pull-up lives in the pad; low level means disabled
		case (st_r.state)
			ST_OFF: begin
				if (st_r.s2[IX_EN]) begin
					st_nxt.state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				// mode caught once; a moving mode pin must not retarget pins
				if (st_r.s2[IX_MLO]) begin
					st_nxt.mode = MODE_PWM;
				end else if (st_r.s2[IX_MHI]) begin
					st_nxt.mode = MODE_DC;
				end else begin
					st_nxt.mode = MODE_SER;
				end
				st_nxt.slave = st_r.s2[IX_SLAVE];
				st_nxt.state = st_r.s2[IX_EN] ? ST_RUN : ST_OFF;
			end
			ST_RUN: begin
				if (!st_r.s2[IX_EN]) begin
					st_nxt.state = ST_OFF;
				end
			end
			default: begin
				st_nxt.state = ST_OFF;
			end
		endcase

		// internal clock: forced external clock or the divided oscillator
		if (st_r.s2[IX_EXT]) begin
			tick = rise_of(st_r.s2, st_r.s3, IX_FS);
			st_nxt.osc_cnt = 8'h00;
		end else if (st_r.osc_cnt >= OSC_DIV - 8'h01) begin
			tick = 1'b1;
			st_nxt.osc_cnt = 8'h00;
		end else begin
			st_nxt.osc_cnt = st_r.osc_cnt + 8'h01;
		end

		// cascade clock toggles once per internal tick
		if (tick) begin
			st_nxt.half_clk = ~st_r.half_clk;
			if (!st_r.half_clk) begin
				// only moves on the cascade clock rise so slaves sample clean
				st_nxt.turn_on = (st_r.state == ST_RUN) && st_r.s2[IX_RAIL]
					&& !st_r.ctrl_off;
			end
		end

		// serial shift path
		ser_run = (st_r.state == ST_RUN) && (st_r.mode == MODE_SER);
		if (ser_run && rise_of(st_r.s2, st_r.s3, IX_D23)) begin
			st_nxt.shift = {st_r.shift[SHIFT_W-2:0], st_r.s2[IX_D01]};
		end

		// load: arm only after the pin is seen high again, since our own
		// drive keeps the synchronised pin low for a few cycles afterwards
		load_start = ser_run && st_r.load_armed && (st_r.load_cnt == 4'h0)
			&& !st_r.s2[IX_D4];
		if (load_start) begin
			st_nxt.act = st_r.shift;
			st_nxt.load_cnt = LOAD_CYC;
			st_nxt.load_armed = 1'b0;
			ev[EV_LOAD] = 1'b1;
		end else if (st_r.load_cnt != 4'h0) begin
			st_nxt.load_cnt = st_r.load_cnt - 4'h1;
		end else if (st_r.s2[IX_D4]) begin
			st_nxt.load_armed = 1'b1;
		end

		// slave in pwm mode takes the sync line as pretest timing
		st_nxt.pretest = (st_r.state == ST_RUN) && (st_r.mode == MODE_PWM)
			&& st_r.slave && rise_of(st_r.s2, st_r.s3, IX_SYNC);
		ev[EV_PRETEST] = st_nxt.pretest;

		// fault flag follows the open-string detector
		st_nxt.fault_drv = st_r.s2[IX_FAULT];
		ev[EV_FAULT] = rise_of(st_r.s2, st_r.s3, IX_FAULT);

		// channel gates; dc duty conversion sits outside this block
		st_nxt.ch_en = 6'h00;
		if (st_r.state == ST_RUN && !st_r.ctrl_off) begin
			if (st_r.mode == MODE_PWM) begin
				st_nxt.ch_en[1:0] = {2{st_r.s2[IX_D01]}};
				st_nxt.ch_en[3:2] = {2{st_r.s2[IX_D23]}};
				st_nxt.ch_en[4] = st_r.s2[IX_D4];
				st_nxt.ch_en[5] = st_r.s2[IX_D5];
			end else if (st_r.mode == MODE_SER) begin
				st_nxt.ch_en = st_r.act[5:0];
			end
		end

		// register writes
		if (wr_in) begin
			case (addr_in)
				OFS_CLEAR: clr = wdata_in[EV_W-1:0];
				OFS_IEN: st_nxt.ien = wdata_in[EV_W-1:0];
				OFS_CTRL: st_nxt.ctrl_off = wdata_in[0];
				default: ;
			endcase
		end
		// a set in the clearing cycle survives
		st_nxt.sts = (st_r.sts & ~clr) | ev;

		// read data stands for the one cycle after the strobe only
		st_nxt.rdata = 8'h00;
		if (rd_in) begin
			case (addr_in)
				OFS_STATUS: st_nxt.rdata = {5'h00, st_r.sts};
				OFS_IEN: st_nxt.rdata = {5'h00, st_r.ien};
				OFS_CTRL: st_nxt.rdata = {7'h00, st_r.ctrl_off};
				OFS_ACTIVE: st_nxt.rdata = st_r.act;
				OFS_INFO: st_nxt.rdata = {st_r.slave, st_r.mode, st_r.state, 2'h0};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '{s1: '0, s2: '0, s3: '0, state: ST_OFF, mode: MODE_PWM,
				slave: 1'b0, osc_cnt: 8'h00, half_clk: 1'b0, turn_on: 1'b0,
				shift: ACT_RST, act: ACT_RST, load_cnt: 4'h0, load_armed: 1'b0,
				sts: '0, ien: '0, ctrl_off: 1'b0, rdata: 8'h00, pretest: 1'b0,
				fault_drv: 1'b0, ch_en: 6'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// load pin: open-drain style, driven low only during a load
	assign ch4_gate_load_pin_out = 1'b0;
	assign ch4_gate_load_pin_oe_n_out = (st_r.load_cnt == 4'h0);
	// sync line is an input on a slave, the turn-on output on a master
	assign cascade_sync_pin_out = st_r.turn_on;
	assign cascade_sync_pin_oe_n_out = st_r.slave;
	assign cascade_half_rate_clock_out = st_r.half_clk;
	assign fault_flag_out = 1'b0;
	assign fault_flag_oe_n_out = ~st_r.fault_drv;
	assign ch_en_out = st_r.ch_en;
	assign pretest_start_out = st_r.pretest;
	assign rdata_out = st_r.rdata;
	// irq is built from registers only, so it cannot glitch between edges
	assign irq_out = |(st_r.sts & st_r.ien);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// pwm gates follow the synchronised pins one cycle later
	a_pair01_gate: assert property (st_r.state == ST_RUN && st_r.mode == MODE_PWM
		&& !st_r.ctrl_off |=> ch_en_out[1:0] == {2{$past(st_r.s2[IX_D01])}})
		else $error("pair01 gate mismatch");
	a_pair23_gate: assert property (st_r.state == ST_RUN && st_r.mode == MODE_PWM
		&& !st_r.ctrl_off |=> ch_en_out[3:2] == {2{$past(st_r.s2[IX_D23])}})
		else $error("pair23 gate mismatch");
	a_ch4_gate: assert property (st_r.state == ST_RUN && st_r.mode == MODE_PWM
		&& !st_r.ctrl_off |=> ch_en_out[4] == $past(st_r.s2[IX_D4]))
		else $error("ch4 gate mismatch");
	a_ch5_gate: assert property (st_r.state == ST_RUN && st_r.mode == MODE_PWM
		&& !st_r.ctrl_off |=> ch_en_out[5] == $past(st_r.s2[IX_D5]))
		else $error("ch5 gate mismatch");

	// serial path: shifting, latching and the load hold
	a_serial_shift: assert property (ser_run && rise_of(st_r.s2, st_r.s3, IX_D23)
		|=> st_r.shift[0] == $past(st_r.s2[IX_D01]))
		else $error("serial bit not shifted");
	// outside serial running the holding register must not move
	a_shift_idle: assert property (!ser_run |=> $stable(st_r.shift))
		else $error("shift moved outside serial mode");
	a_load_latch: assert property (load_start
		|=> st_r.act == $past(st_r.shift))
		else $error("load did not latch");
	a_load_hold: assert property (load_start
		|=> (!ch4_gate_load_pin_oe_n_out)[*4] ##1 ch4_gate_load_pin_oe_n_out)
		else $error("load pin hold wrong");
	// serial mode channel gates come from the latched word only
	a_serial_gate: assert property (st_r.state == ST_RUN && st_r.mode == MODE_SER
		&& !st_r.ctrl_off |=> ch_en_out == $past(st_r.act[5:0]))
		else $error("serial channel gates wrong");

	// cascade clock and turn-on line
	a_half_rate: assert property (tick
		|=> cascade_half_rate_clock_out != $past(cascade_half_rate_clock_out))
		else $error("cascade clock missed toggle");
	// between forced clock edges the cascade clock must hold still
	a_ext_hold: assert property (st_r.s2[IX_EXT] && !rise_of(st_r.s2, st_r.s3, IX_FS)
		|=> $stable(cascade_half_rate_clock_out))
		else $error("cascade clock moved without a forced edge");
	a_turn_on_step: assert property ($changed(st_r.turn_on)
		|-> $rose(cascade_half_rate_clock_out))
		else $error("turn-on moved off clock rise");
	// pretest pulse on a pwm slave after each sync rise, none on a master
	a_pretest_pulse: assert property (st_r.state == ST_RUN && st_r.mode == MODE_PWM
		&& st_r.slave && rise_of(st_r.s2, st_r.s3, IX_SYNC) |=> pretest_start_out)
		else $error("pretest pulse missing");
	a_pretest_master: assert property (!st_r.slave |=> !pretest_start_out)
		else $error("pretest pulse on a master");

	// fault flag both ways
	a_fault_pull: assert property (st_r.s2[IX_FAULT] |=> !fault_flag_oe_n_out)
		else $error("fault flag not pulled");
	a_fault_free: assert property (!st_r.s2[IX_FAULT] |=> fault_flag_oe_n_out)
		else $error("fault flag held without a fault");

	// enable, mode and slave decode
	a_enable_off: assert property (!st_r.s2[IX_EN] |-> ##2 ch_en_out == 6'h00)
		else $error("channels on while disabled");
	a_mode_pick: assert property (st_r.state == ST_DECODE && st_r.s2[IX_MLO]
		|=> st_r.mode == MODE_PWM)
		else $error("grounded mode pin not taken as pwm");
	a_dc_dark: assert property (st_r.state == ST_RUN && st_r.mode == MODE_DC
		|=> ch_en_out == 6'h00)
		else $error("channel gated in dc mode");
	a_slave_pick: assert property (st_r.state == ST_DECODE
		|=> st_r.slave == $past(st_r.s2[IX_SLAVE]))
		else $error("slave strap not captured");
	a_mode_held: assert property (st_r.state == ST_RUN && $past(st_r.state) == ST_RUN
		|-> $stable(st_r.mode))
		else $error("mode changed while running");

	// register side: set beats clear, read data stands one cycle, off forces dark
	a_set_wins: assert property (|ev |=> (st_r.sts & $past(ev)) == $past(ev))
		else $error("status event lost");
	a_read_once: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data stood too long");
	a_ctrl_dark: assert property (st_r.ctrl_off |=> ch_en_out == 6'h00)
		else $error("channels on while forced off");

endmodule

// >>> ldi_host.sv
// ldi_host: behavioural host controller on the dimming and serial pins.
// assumes the bench resolves the open-drain load wire and feeds it back.
`timescale 1ns/1ns
module ldi_host (
	input wire logic clk_in,
	input wire logic load_wire_in,
	output logic pair01_out,
	output logic pair23_out,
	output logic load_drv_out,
	output logic load_en_out,
	output logic ch5_out
);
	// idle: serial clock low, load pin driven high
	initial begin
		pair01_out = 1'b0;
		pair23_out = 1'b0;
		load_drv_out = 1'b1;
		load_en_out = 1'b1;
		ch5_out = 1'b0;
	end
	// pwm gate levels, changed just after a core edge
	task automatic gates(input logic [3:0] g);
		@(posedge clk_in);
		pair01_out <= g[0];
		pair23_out <= g[1];
		load_drv_out <= g[2];
		load_en_out <= 1'b1;
		ch5_out <= g[3];
	endtask
	// one byte msb first, 800 ns period; clock stands low between frames
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_in);
			pair01_out <= b[i];
			pair23_out <= 1'b0;
			repeat (4) @(posedge clk_in);
			pair23_out <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
		@(posedge clk_in);
		pair23_out <= 1'b0;
		pair01_out <= ~b[0]; // stale data shows the inverse, never the last bit
	endtask
	// load pulse, then wait while the device still holds the wire low
	task automatic load();
		int n;
		n = 0;
		@(posedge clk_in);
		load_en_out <= 1'b1;
		load_drv_out <= 1'b0;
		repeat (6) @(posedge clk_in);
		load_en_out <= 1'b0;
		@(posedge clk_in);
		while (load_wire_in === 1'b0 && n < 50) begin
			n++;
			@(posedge clk_in);
		end
	endtask
endmodule

// >>> ldi_tb.sv
// ldi_tb: self-checking bench for the dimming input block.
// assumes ldi_pkg and ldi_core; the load wire has a pull-up on the host side.
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench
	import ldi_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic en = 1'b1, gnd = 1'b1, open_s = 1'b0, ext_sel = 1'b0, ext_clk = 1'b0;
	logic wr = 1'b0, rd = 1'b0, ps = 1'b0, pc = 1'b0;
	logic vcc = 1'b0, rail = 1'b0, rail_ok = 1'b1, sync = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic d01, d23, ld_drv, ld_en, d5, ld_out, ld_oe_n, s_out, s_oe_n, half, flt, flt_oe_n;
	logic pre, irq, ld_wire;
	logic [5:0] ch_en;
	logic [7:0] rdata;
	int mismatches = 0, comparisons = 0;
	// open-drain load wire: either party may pull it low
	assign ld_wire = (ld_en ? ld_drv : 1'b1) & (ld_oe_n ? 1'b1 : ld_out);
	always #50 clk_in = ~clk_in;
	// forced clock on the frequency pin, 1000 ns period, moved on core edges
	always begin
		repeat (5) @(posedge clk_in);
		ext_clk <= ~ext_clk;
	end
	ldi_core u_ldi_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.pair01_gate_serdata_pin_in(d01), .pair23_gate_serclk_pin_in(d23),
		.ch4_gate_load_pin_in(ld_wire), .ch4_gate_load_pin_out(ld_out),
		.ch4_gate_load_pin_oe_n_out(ld_oe_n), .ch5_gate_pin_in(d5),
		.osc_freq_set_pin_in(ext_clk), .ext_clk_sel_in(ext_sel), .enable_pin_in(en),
		.mode_at_vcc_in(vcc), .mode_at_gnd_in(gnd), .rail_sense_input_in(rail),
		.rail_ok_in(rail_ok), .open_string_in(open_s), .cascade_sync_pin_in(sync),
		.cascade_sync_pin_out(s_out), .cascade_sync_pin_oe_n_out(s_oe_n),
		.cascade_half_rate_clock_out(half), .fault_flag_out(flt),
		.fault_flag_oe_n_out(flt_oe_n), .ch_en_out(ch_en), .pretest_start_out(pre),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.irq_out(irq));
	ldi_host u_ldi_host (.clk_in(clk_in), .load_wire_in(ld_wire), .pair01_out(d01),
		.pair23_out(d23), .load_drv_out(ld_drv), .load_en_out(ld_en), .ch5_out(d5));
	// turn-on may only move on a rising cascade clock edge
	always @(posedge clk_in) begin
		if (rst_n_in && s_out !== ps && !(half === 1'b1 && pc === 1'b0))
			`CHK("turn_on", ps, s_out)
		ps <= s_out;
		pc <= half;
	end
	// ----------------------------------------
	// bus and timing helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 `CHK(nm, e, rdata)
	endtask
	// cycles the device keeps the load wire pulled low
	task automatic load_len(output int n);
		int w;
		w = 0;
		n = 0;
		while (ld_oe_n !== 1'b0 && w < 40) begin @(posedge clk_in); #1 w++; end
		while (ld_oe_n === 1'b0 && n < 40) begin @(posedge clk_in); #1 n++; end
	endtask
	task automatic write_load(input logic [7:0] b, input logic [7:0] e6);
		int n;
		u_ldi_host.send(b);
		fork
			u_ldi_host.load();
			load_len(n);
		join
		`CHK("load hold", LOAD_CYC_I, n)
		rd_chk(OFS_ACTIVE, b, "active");
		`CHK("ch_en serial", e6[5:0], ch_en)
	endtask
	// disable and pick mode, check all off, enable again
	task automatic set_mode(input logic g);
		@(posedge clk_in);
		en <= 1'b0;
		gnd <= g;
		cyc(8);
		#1 `CHK("ch_en disabled", 6'h00, ch_en)
		@(posedge clk_in);
		en <= 1'b1;
		cyc(10);
	endtask
	task automatic gap(output int n);
		time t0;
		@(posedge half) t0 = $time;
		@(posedge half) n = int'(($time - t0) / 100);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		`CHK("ch_en reset", 6'h00, ch_en)
		`CHK("load oe_n reset", 1'b1, ld_oe_n)
		`CHK("fault oe_n reset", 1'b1, flt_oe_n)
		`CHK("sync oe_n reset", 1'b0, s_oe_n)
		cyc(10);
		rd_chk(OFS_INFO, 8'h10, "info pwm");
		rd_chk(OFS_IEN, 8'h00, "ien reset");
		rd_chk(5'h1C, 8'h00, "unmapped");
		rd_chk(OFS_CLEAR, 8'h00, "clear read");
		$display("test reset done");
	endtask
	task automatic t_pwm();
		logic [3:0] g;
		for (int i = 0; i < 16; i++) begin
			g = i[3:0];
			u_ldi_host.gates(g);
			cyc(6);
			#1 `CHK("ch_en pwm", {g[3], g[2], g[1], g[1], g[0], g[0]}, ch_en)
		end
		wr_reg(OFS_CTRL, 8'h01);
		#100 `CHK("ch_en forced", 6'h00, ch_en)
		rd_chk(OFS_CTRL, 8'h01, "ctrl read");
		wr_reg(OFS_CTRL, 8'h00);
		$display("test pwm done");
	endtask
	task automatic t_serial();
		u_ldi_host.gates(4'b0100);
		set_mode(1'b0);
		@(posedge clk_in);
		gnd <= 1'b1;
		cyc(6);
		rd_chk(OFS_INFO, 8'h30, "info serial held");
		wr_reg(OFS_IEN, 8'h01);
		write_load(8'hA5, 8'h25);
		`CHK("irq load", 1'b1, irq)
		wr_reg(OFS_IEN, 8'h00);
		`CHK("irq masked", 1'b0, irq)
		wr_reg(OFS_IEN, 8'h01);
		rd_chk(OFS_STATUS, 8'h01, "status load");
		wr_reg(OFS_CLEAR, 8'h01);
		`CHK("irq cleared", 1'b0, irq)
		write_load(8'h3C, 8'h3C);
		u_ldi_host.send(8'h0F);
		rd_chk(OFS_ACTIVE, 8'h3C, "active without load");
		$display("test serial done");
	endtask
	task automatic t_fault();
		@(posedge clk_in);
		open_s <= 1'b1;
		cyc(6);
		#1 `CHK("fault oe_n", 1'b0, flt_oe_n)
		`CHK("fault level", 1'b0, flt)
		rd_chk(OFS_STATUS, 8'h03, "status fault");
		@(posedge clk_in);
		open_s <= 1'b0;
		cyc(6);
		#1 `CHK("fault released", 1'b1, flt_oe_n)
		$display("test fault done");
	endtask
	task automatic t_cascade();
		int n;
		gap(n);
		`CHK("osc half period", 2 * int'(OSC_DIV_DEF), n)
		@(posedge clk_in);
		rail_ok <= 1'b0;
		cyc(12);
		#1 `CHK("turn_on rail low", 1'b0, s_out)
		@(posedge clk_in);
		rail_ok <= 1'b1;
		cyc(12);
		#1 `CHK("turn_on rail ok", 1'b1, s_out)
		@(posedge clk_in);
		ext_sel <= 1'b1;
		cyc(50);
		gap(n);
		`CHK("ext half period", 20, n)
		$display("test cascade done");
	endtask
	task automatic t_slave();
		@(posedge clk_in);
		rail <= 1'b1;
		set_mode(1'b1);
		rd_chk(OFS_INFO, 8'h90, "info slave");
		`CHK("sync oe_n slave", 1'b1, s_oe_n)
		wr_reg(OFS_CLEAR, 8'h07);
		wr_reg(OFS_IEN, 8'h04);
		@(posedge clk_in);
		sync <= 1'b1;
		cyc(3);
		#1 `CHK("pretest", 1'b1, pre)
		`CHK("irq pretest", 1'b1, irq)
		cyc(1);
		#1 `CHK("pretest width", 1'b0, pre)
		rd_chk(OFS_STATUS, 8'h04, "status pretest");
		$display("test slave done");
	endtask
	task automatic t_dc();
		@(posedge clk_in);
		rail <= 1'b0;
		vcc <= 1'b1;
		set_mode(1'b0);
		rd_chk(OFS_INFO, 8'h50, "info dc");
		u_ldi_host.gates(4'hF);
		cyc(6);
		#1 `CHK("ch_en dc", 6'h00, ch_en)
		`CHK("sync oe_n master", 1'b0, s_oe_n)
		$display("test dc done");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		cyc(2);
		rst_n_in <= 1'b1;
		#1 t_reset();
		t_pwm();
		t_serial();
		t_fault();
		t_cascade();
		t_slave();
		t_dc();
		results();
	end
	// all scenarios take well under 100 us
	initial begin
		#200_000;
		mismatches++;
		results();
	end
endmodule
